// ### core/lrr_device.sv
`timescale 1ns/1ps
// Overview of operation
// - Delay reset released synchronously to its clock.
// - Every reset held at least one cycle.
// - Register reset released synchronously to core clock.
// - Request after four consecutive frames, when enabled.
// - Request output cleared while in reset.
// - Send enabled reset request in Z.130.0 bit0.
// - Reset send input sampled on core edge.
// - Recovered clock and core clock observation outputs.
// - Registers 32 bits, word accesses only.
// - Software avoids writing or trusting reserved bits.
// - Registers reachable only through CPU interface.
// - Read-clear, read-only, read/write, write-only behaviours.
// - Decode link, map, Ethernet, HDLC ranges.
// - Report and send enables at offset 0x20.
// - Interrupt control bit1 enables reset interrupt.
module lrr_device #(
    parameter int CONSEC_FRAMES = lrr_pkg::RESET_CONSEC_FRAMES,
    parameter int BF_CYCLES = lrr_pkg::BF_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_ARST_N,
    lrr_link_if.device LINK,
    input wire logic I_LINK_RESET_SEND_IN,
    output logic O_LINK_RESET_REQUEST_OUT,
    output logic O_IRQ,
    output logic O_RECOVERED_CLK,
    output logic O_CORE_CLK_OBS
);
    import lrr_pkg::*;

    localparam int BF_W = (BF_CYCLES < 2) ? 1 : $clog2(BF_CYCLES);
    localparam logic [BF_W-1:0] BF_LAST = BF_W'(BF_CYCLES - 1);
    localparam logic [2:0] CONSEC_LAST = 3'(CONSEC_FRAMES - 1);
    localparam logic [2:0] CONSEC_TOP = 3'(CONSEC_FRAMES);

    if (CONSEC_FRAMES < 1 || CONSEC_FRAMES > 7) begin : g_bad_consec
        $error("CONSEC_FRAMES must lie in 1..7");
    end
    if (BF_CYCLES < 1) begin : g_bad_bf
        $error("BF_CYCLES must be at least 1");
    end

    typedef struct packed {
        logic intr_en;
        logic irq_reset_en;
        logic los_lcv_en;
        logic report_en;
        logic send_en;
        logic [2:0] consec;
        logic req_out;
        logic rx_hold;
        logic pend;
        logic irq;
        logic send_smp;
        logic delay_rst;
        logic [BF_W-1:0] bf_div;
        logic [7:0] bf_index;
        logic tx_bf;
        logic tx_bit;
        logic [DATA_W-1:0] rdata;
        lrr_region_type last_region;
        logic rec_clk;
        logic core_obs;
    } lrr_dev_state_type;

    lrr_dev_state_type st;
    lrr_dev_state_type next_st;
    lrr_region_type region;

    function automatic lrr_region_type region_of(input logic [ADDR_W-1:0] a);
        // Sub-word addresses never hit a register
        if (a[1:0] != 2'h0) begin
            return LRR_REG_RESERVED;
        end else if (a <= LINK_HI) begin
            return LRR_REG_LINK;
        end else if (a >= MAP_LO && a <= MAP_HI) begin
            return LRR_REG_MAP;
        end else if (a >= ETH_LO && a <= ETH_HI) begin
            return LRR_REG_ETH;
        end else if (a >= HDLC_LO && a <= HDLC_HI) begin
            return LRR_REG_HDLC;
        end else begin
            return LRR_REG_RESERVED;
        end
    endfunction

    assign region = region_of(LINK.cpu_addr);

    always_comb begin
        next_st = st;
        next_st.tx_bf = 1'b0;
        next_st.tx_bit = 1'b0;
        next_st.rdata = '0;
        next_st.core_obs = ~st.core_obs;
        next_st.send_smp = I_LINK_RESET_SEND_IN;
        // Same-clock source, so a plain sample is enough
        next_st.delay_rst = ~LINK.delay_measure_block_reset_n;

        if (LINK.cpu_wr || LINK.cpu_rd) begin
            next_st.last_region = region;
        end

        // Only the link range lives here; other ranges read zero
        if (LINK.cpu_rd && region == LRR_REG_LINK) begin
            if (LINK.cpu_addr == OFS_INTR_CTRL) begin
                next_st.rdata[INTR_EN_BIT] = st.intr_en;
                next_st.rdata[IRQ_RESET_EN_BIT] = st.irq_reset_en;
                next_st.rdata[LOS_LCV_EN_BIT] = st.los_lcv_en;
            end else if (LINK.cpu_addr == OFS_LINK_STATUS) begin
                next_st.rdata[ST_REQ_BIT] = st.req_out;
                next_st.rdata[ST_RX_HOLD_BIT] = st.rx_hold;
                next_st.rdata[ST_DELAY_RST_BIT] = st.delay_rst;
                next_st.rdata[ST_REGION_LSB +: 3] = st.last_region;
                next_st.rx_hold = 1'b0;
            end else if (LINK.cpu_addr == OFS_HARD_RESET) begin
                next_st.rdata[HR_REPORT_EN_BIT] = st.report_en;
                next_st.rdata[HR_SEND_EN_BIT] = st.send_en;
            end else if (LINK.cpu_addr == OFS_IRQ_PEND) begin
                next_st.rdata[PEND_RX_RESET_BIT] = st.pend;
            end else begin
                next_st.rdata = '0;
            end
        end

        // Status and pending registers ignore writes
        if (LINK.cpu_wr && region == LRR_REG_LINK) begin
            if (LINK.cpu_addr == OFS_INTR_CTRL) begin
                next_st.intr_en = LINK.cpu_wdata[INTR_EN_BIT];
                next_st.irq_reset_en = LINK.cpu_wdata[IRQ_RESET_EN_BIT];
                next_st.los_lcv_en = LINK.cpu_wdata[LOS_LCV_EN_BIT];
            end else if (LINK.cpu_addr == OFS_HARD_RESET) begin
                next_st.report_en = LINK.cpu_wdata[HR_REPORT_EN_BIT];
                next_st.send_en = LINK.cpu_wdata[HR_SEND_EN_BIT];
            end else if (LINK.cpu_addr == OFS_IRQ_CLEAR) begin
                if (LINK.cpu_wdata[PEND_RX_RESET_BIT]) begin
                    next_st.pend = 1'b0;
                end
            end
        end

        // Receive side: count frames that carry the reset bit
        if (LINK.rx_bf) begin
            next_st.rec_clk = ~st.rec_clk;
            if (LINK.rx_reset_bit) begin
                if (st.consec != CONSEC_TOP) begin
                    next_st.consec = 3'(st.consec + 3'h1);
                end
                // Detection sets flags after the clears, so it wins
                if (st.consec >= CONSEC_LAST && st.report_en && !st.req_out) begin
                    next_st.req_out = 1'b1;
                    next_st.rx_hold = 1'b1;
                    next_st.pend = 1'b1;
                end
            end else begin
                // A missing bit breaks the run; the request itself holds
                next_st.consec = 3'h0;
            end
        end

        // Transmit side: basic frame timing and Z.130.0 insertion
        if (st.bf_div == BF_LAST) begin
            next_st.bf_div = '0;
            next_st.tx_bf = 1'b1;
            next_st.bf_index = 8'(st.bf_index + 8'h01);
            if (next_st.bf_index == Z_CTRL_INDEX) begin
                next_st.tx_bit = st.send_smp && st.send_en;
            end
        end else begin
            next_st.bf_div = BF_W'(st.bf_div + 1'b1);
        end

        next_st.irq = next_st.intr_en && next_st.irq_reset_en && next_st.pend;

        // Register reset clears everything, the request included
        if (!LINK.cfg_reset_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign LINK.cpu_rdata = st.rdata;
    assign LINK.tx_bf = st.tx_bf;
    assign LINK.tx_bf_index = st.bf_index;
    assign LINK.tx_reset_bit = st.tx_bit;
    assign O_LINK_RESET_REQUEST_OUT = st.req_out;
    assign O_IRQ = st.irq;
    assign O_RECOVERED_CLK = st.rec_clk;
    assign O_CORE_CLK_OBS = st.core_obs;

endmodule // lrr_device

// ### core/lrr_pkg.sv
package lrr_pkg;

    // Bus geometry
    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;

    // Device register offsets (byte addresses, word aligned)
    localparam logic [9:0] OFS_INTR_CTRL = 10'h000;
    localparam logic [9:0] OFS_LINK_STATUS = 10'h004;
    localparam logic [9:0] OFS_HARD_RESET = 10'h020;
    localparam logic [9:0] OFS_IRQ_CLEAR = 10'h044;
    localparam logic [9:0] OFS_IRQ_PEND = 10'h04c;

    // Address ranges
    localparam logic [9:0] LINK_HI = 10'h04c;
    localparam logic [9:0] MAP_LO = 10'h050;
    localparam logic [9:0] MAP_HI = 10'h0f0;
    localparam logic [9:0] ETH_LO = 10'h200;
    localparam logic [9:0] ETH_HI = 10'h24c;
    localparam logic [9:0] HDLC_LO = 10'h300;
    localparam logic [9:0] HDLC_HI = 10'h334;

    // Interrupt control fields
    localparam int INTR_EN_BIT = 0;
    localparam int IRQ_RESET_EN_BIT = 1;
    localparam int LOS_LCV_EN_BIT = 5;
    localparam logic INTR_CTRL_RESET = 1'h0;

    // Hard reset control fields
    localparam int HR_REPORT_EN_BIT = 0;
    localparam int HR_SEND_EN_BIT = 1;

    // Link status fields
    localparam int ST_REQ_BIT = 0;
    localparam int ST_RX_HOLD_BIT = 1;
    localparam int ST_DELAY_RST_BIT = 2;
    localparam int ST_REGION_LSB = 4;

    // Pending interrupt / clear layout
    localparam int PEND_RX_RESET_BIT = 1;

    // Link framing
    localparam int RESET_CONSEC_FRAMES = 4;
    localparam logic [7:0] Z_CTRL_INDEX = 8'h82;
    localparam int CLK_PERIOD_PS = 100000;
    localparam int BF_PERIOD_PS = 260417;
    localparam int BF_CYCLES_RAW = BF_PERIOD_PS / CLK_PERIOD_PS;
    localparam int BF_CYCLES = (BF_CYCLES_RAW < 1) ? 1 : BF_CYCLES_RAW;

    // Host controller register offsets
    localparam logic [7:0] H_OFS_CMD = 8'h00;
    localparam logic [7:0] H_OFS_ADDR = 8'h04;
    localparam logic [7:0] H_OFS_WDATA = 8'h08;
    localparam logic [7:0] H_OFS_RDATA = 8'h0c;
    localparam logic [7:0] H_OFS_STATUS = 8'h10;
    localparam logic [7:0] H_OFS_CTRL = 8'h14;

    // Host fields
    localparam int H_CMD_WRITE_BIT = 0;
    localparam int H_CMD_READ_BIT = 1;
    localparam int H_ST_BUSY_BIT = 0;
    localparam int H_ST_Z_BIT = 1;
    localparam int H_ST_REQ_SEEN_BIT = 2;
    localparam int H_CTRL_CFG_RST_BIT = 0;
    localparam int H_CTRL_DLY_RST_BIT = 1;
    localparam int H_CTRL_RESET_BIT = 2;
    localparam int H_CTRL_FRAMES_BIT = 3;
    localparam logic [3:0] H_CTRL_RESET_VAL = 4'h3;

    typedef enum logic [2:0] {
        LRR_REG_RESERVED = 3'h0,
        LRR_REG_LINK = 3'h1,
        LRR_REG_MAP = 3'h2,
        LRR_REG_ETH = 3'h3,
        LRR_REG_HDLC = 3'h4
    } lrr_region_type;

    typedef enum logic [1:0] {
        LRR_H_IDLE = 2'b00,
        LRR_H_ISSUE = 2'b01,
        LRR_H_CAPTURE = 2'b11
    } lrr_host_state_type;

endpackage

// ### core/lrr_link_if.sv
`timescale 1ns/1ps
interface lrr_link_if;
    logic cfg_reset_n;
    logic delay_measure_block_reset_n;
    logic [lrr_pkg::ADDR_W-1:0] cpu_addr;
    logic [lrr_pkg::DATA_W-1:0] cpu_wdata;
    logic cpu_wr;
    logic cpu_rd;
    logic [lrr_pkg::DATA_W-1:0] cpu_rdata;
    logic rx_bf;
    logic rx_reset_bit;
    logic tx_bf;
    logic [7:0] tx_bf_index;
    logic tx_reset_bit;

    modport device (
        input cfg_reset_n,
        input delay_measure_block_reset_n,
        input cpu_addr,
        input cpu_wdata,
        input cpu_wr,
        input cpu_rd,
        output cpu_rdata,
        input rx_bf,
        input rx_reset_bit,
        output tx_bf,
        output tx_bf_index,
        output tx_reset_bit
    );

    modport host (
        output cfg_reset_n,
        output delay_measure_block_reset_n,
        output cpu_addr,
        output cpu_wdata,
        output cpu_wr,
        output cpu_rd,
        input cpu_rdata,
        output rx_bf,
        output rx_reset_bit,
        input tx_bf,
        input tx_bf_index,
        input tx_reset_bit
    );
endinterface

// ### core/lrr_host.sv
`timescale 1ns/1ps
module lrr_host #(
    parameter int BF_CYCLES = lrr_pkg::BF_CYCLES
) (
    input wire logic I_CORE_CLK,
    input wire logic I_ARST_N,
    lrr_link_if.host LINK,
    input wire logic [7:0] I_ADDR,
    input wire logic [lrr_pkg::DATA_W-1:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [lrr_pkg::DATA_W-1:0] O_RDATA
);
    import lrr_pkg::*;

    localparam int BF_W = (BF_CYCLES < 2) ? 1 : $clog2(BF_CYCLES);
    localparam logic [BF_W-1:0] BF_LAST = BF_W'(BF_CYCLES - 1);

    if (BF_CYCLES < 1) begin : g_bad_bf
        $error("BF_CYCLES must be at least 1");
    end

    typedef struct packed {
        lrr_host_state_type fsm;
        logic is_read;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata_cap;
        logic [3:0] ctrl;
        logic z_seen;
        logic cpu_wr;
        logic cpu_rd;
        logic cfg_rst_n;
        logic dly_rst_n;
        logic [BF_W-1:0] bf_div;
        logic rx_bf;
        logic rx_bit;
        logic [DATA_W-1:0] o_rdata;
    } lrr_host_reg_type;

    lrr_host_reg_type st;
    lrr_host_reg_type next_st;

    always_comb begin
        next_st = st;
        next_st.cpu_wr = 1'b0;
        next_st.cpu_rd = 1'b0;
        next_st.rx_bf = 1'b0;
        next_st.o_rdata = '0;

        if (I_RD) begin
            if (I_ADDR == H_OFS_ADDR) begin
                next_st.o_rdata = DATA_W'(st.addr);
            end else if (I_ADDR == H_OFS_WDATA) begin
                next_st.o_rdata = st.wdata;
            end else if (I_ADDR == H_OFS_RDATA) begin
                next_st.o_rdata = st.rdata_cap;
            end else if (I_ADDR == H_OFS_STATUS) begin
                next_st.o_rdata[H_ST_BUSY_BIT] = (st.fsm != LRR_H_IDLE);
                next_st.o_rdata[H_ST_Z_BIT] = st.z_seen;
            end else if (I_ADDR == H_OFS_CTRL) begin
                next_st.o_rdata = DATA_W'(st.ctrl);
            end
        end

        if (I_WR) begin
            if (I_ADDR == H_OFS_ADDR) begin
                next_st.addr = I_WDATA[ADDR_W-1:0];
            end else if (I_ADDR == H_OFS_WDATA) begin
                next_st.wdata = I_WDATA;
            end else if (I_ADDR == H_OFS_CTRL) begin
                next_st.ctrl = I_WDATA[3:0];
            end else if (I_ADDR == H_OFS_STATUS) begin
                // Write one to drop the captured Z.130.0 flag
                if (I_WDATA[H_ST_Z_BIT]) begin
                    next_st.z_seen = 1'b0;
                end
            end
        end

        // One transaction at a time; commands while busy are dropped
        case (st.fsm)
            LRR_H_IDLE: begin
                if (I_WR && I_ADDR == H_OFS_CMD) begin
                    if (I_WDATA[H_CMD_WRITE_BIT]) begin
                        next_st.cpu_wr = 1'b1;
                        next_st.is_read = 1'b0;
                        next_st.fsm = LRR_H_ISSUE;
                    end else if (I_WDATA[H_CMD_READ_BIT]) begin
                        next_st.cpu_rd = 1'b1;
                        next_st.is_read = 1'b1;
                        next_st.fsm = LRR_H_ISSUE;
                    end
                end
            end
            LRR_H_ISSUE: begin
                next_st.fsm = LRR_H_CAPTURE;
            end
            LRR_H_CAPTURE: begin
                if (st.is_read) begin
                    next_st.rdata_cap = LINK.cpu_rdata;
                end
                next_st.fsm = LRR_H_IDLE;
            end
            default: begin
                next_st.fsm = LRR_H_IDLE;
            end
        endcase

        // Flops give release on a core edge and at least one cycle low
        next_st.cfg_rst_n = ~st.ctrl[H_CTRL_CFG_RST_BIT];
        next_st.dly_rst_n = ~st.ctrl[H_CTRL_DLY_RST_BIT];

        // Partner frames, carrying the reset bit when its control bit is set
        if (st.ctrl[H_CTRL_FRAMES_BIT]) begin
            if (st.bf_div == BF_LAST) begin
                next_st.bf_div = '0;
                next_st.rx_bf = 1'b1;
                next_st.rx_bit = st.ctrl[H_CTRL_RESET_BIT];
            end else begin
                next_st.bf_div = BF_W'(st.bf_div + 1'b1);
            end
        end else begin
            next_st.bf_div = '0;
        end

        if (LINK.tx_bf && LINK.tx_bf_index == Z_CTRL_INDEX && LINK.tx_reset_bit) begin
            next_st.z_seen = 1'b1;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st <= '0;
            st.ctrl <= H_CTRL_RESET_VAL;
        end else begin
            st <= next_st;
        end
    end

    // Word-wide writes only; write data goes out as software wrote it, reserved bits unmasked
    assign LINK.cpu_addr = st.addr;
    assign LINK.cpu_wdata = st.wdata;
    assign LINK.cpu_wr = st.cpu_wr;
    assign LINK.cpu_rd = st.cpu_rd;
    assign LINK.cfg_reset_n = st.cfg_rst_n;
    assign LINK.delay_measure_block_reset_n = st.dly_rst_n;
    assign LINK.rx_bf = st.rx_bf;
    assign LINK.rx_reset_bit = st.rx_bit;
    assign O_RDATA = st.o_rdata;

endmodule // lrr_host

// ### bench/lrr_props.sv
`timescale 1ns/1ps
module lrr_props #(
    parameter int CONSEC_FRAMES = 4
) (
    input wire logic I_CORE_CLK,
    input wire logic I_ARST_N,
    input wire logic cfg_reset_n,
    input wire logic [lrr_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic [lrr_pkg::DATA_W-1:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [lrr_pkg::DATA_W-1:0] cpu_rdata,
    input wire logic rx_bf,
    input wire logic rx_reset_bit,
    input wire logic tx_bf,
    input wire logic [7:0] tx_bf_index,
    input wire logic tx_reset_bit,
    input wire logic I_LINK_RESET_SEND_IN,
    input wire logic O_LINK_RESET_REQUEST_OUT,
    input wire logic O_IRQ,
    input wire logic O_CORE_CLK_OBS
);
    import lrr_pkg::*;
    // Shadow of the enables, snooped from bus writes
    typedef struct packed {
        logic [2:0] run;
        logic report_en;
        logic send_en;
        logic [1:0] irq_en;
        logic [1:0] up;
    } lrr_chk_type;
    lrr_chk_type st;
    lrr_chk_type next_st;

    always_comb begin
        next_st = st;
        if (st.up != 2'h3) begin
            next_st.up = st.up + 2'h1;
        end
        if (rx_bf) begin
            // Saturates so a long run never wraps back into the firing count
            next_st.run = !rx_reset_bit ? 3'h0 : ((st.run == 3'h7) ? st.run : st.run + 3'h1);
        end
        if (cpu_wr && cpu_addr == OFS_HARD_RESET) begin
            next_st.report_en = cpu_wdata[HR_REPORT_EN_BIT];
            next_st.send_en = cpu_wdata[HR_SEND_EN_BIT];
        end
        if (cpu_wr && cpu_addr == OFS_INTR_CTRL) begin
            next_st.irq_en = cpu_wdata[1:0];
        end
        if (!cfg_reset_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_ARST_N);

    req_fire_a: assert property (rx_bf && rx_reset_bit && cfg_reset_n && st.report_en
        && st.run == CONSEC_FRAMES - 1 |=> O_LINK_RESET_REQUEST_OUT)
        else $error("request missing after the frame run");
    req_cause_a: assert property ($rose(O_LINK_RESET_REQUEST_OUT) |->
        $past(rx_bf && rx_reset_bit && st.report_en) && st.run >= CONSEC_FRAMES)
        else $error("request raised without cause");
    req_hold_a: assert property (O_LINK_RESET_REQUEST_OUT && cfg_reset_n |=>
        O_LINK_RESET_REQUEST_OUT)
        else $error("request dropped without reset");
    req_clear_a: assert property (!cfg_reset_n |=> !O_LINK_RESET_REQUEST_OUT)
        else $error("request set during reset");
    rd_idle_a: assert property (!$past(cpu_rd) |-> cpu_rdata == '0)
        else $error("read data outside read slot");
    rd_resv_a: assert property (cpu_rd && (cpu_addr > LINK_HI || cpu_addr[1:0] != 2'h0)
        |=> cpu_rdata == '0)
        else $error("reserved read not zero");
    irq_gate_a: assert property ($rose(O_IRQ) |-> st.irq_en == 2'h3)
        else $error("interrupt raised while disabled");
    tx_slot_a: assert property (tx_reset_bit |-> tx_bf && tx_bf_index == Z_CTRL_INDEX)
        else $error("reset bit outside its control word");
    tx_cause_a: assert property (tx_reset_bit |-> st.send_en &&
        ($past(I_LINK_RESET_SEND_IN) || $past(I_LINK_RESET_SEND_IN, 2)))
        else $error("reset bit sent without request");
    obs_tog_a: assert property (st.up == 2'h3 |-> O_CORE_CLK_OBS != $past(O_CORE_CLK_OBS))
        else $error("core clock observation stuck");

    cover property ($rose(O_LINK_RESET_REQUEST_OUT));
    cover property (O_IRQ);
    cover property (tx_reset_bit);
endmodule // lrr_props

// ### bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import lrr_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic send_in = 1'b0;
    logic [31:0] rdata;
    logic req_out;
    logic irq;
    logic obs;
    logic rclk;
    int rclk_toggles = 0;
    int mismatches = 0;
    int num_checks = 0;

    always #50 core_clk = ~core_clk;

    // Every edge of the frame-rate clock counts once
    always @(rclk) rclk_toggles++;

    lrr_link_if link();
    lrr_device #(.CONSEC_FRAMES(4), .BF_CYCLES(2)) i_lrr_device (.I_CORE_CLK(core_clk),
        .I_ARST_N(arst_n), .LINK(link), .I_LINK_RESET_SEND_IN(send_in),
        .O_LINK_RESET_REQUEST_OUT(req_out), .O_IRQ(irq), .O_RECOVERED_CLK(rclk),
        .O_CORE_CLK_OBS(obs));
    lrr_host #(.BF_CYCLES(2)) i_lrr_host (.I_CORE_CLK(core_clk), .I_ARST_N(arst_n),
        .LINK(link), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata));
    lrr_props #(.CONSEC_FRAMES(4)) i_lrr_props (.I_CORE_CLK(core_clk), .I_ARST_N(arst_n),
        .cfg_reset_n(link.cfg_reset_n), .cpu_addr(link.cpu_addr), .cpu_wdata(link.cpu_wdata),
        .cpu_wr(link.cpu_wr), .cpu_rd(link.cpu_rd), .cpu_rdata(link.cpu_rdata),
        .rx_bf(link.rx_bf), .rx_reset_bit(link.rx_reset_bit), .tx_bf(link.tx_bf),
        .tx_bf_index(link.tx_bf_index), .tx_reset_bit(link.tx_reset_bit),
        .I_LINK_RESET_SEND_IN(send_in), .O_LINK_RESET_REQUEST_OUT(req_out), .O_IRQ(irq),
        .O_CORE_CLK_OBS(obs));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic hwr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic hrd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic dev_wr(input logic [9:0] a, input logic [31:0] d);
        hwr(H_OFS_ADDR, {22'h0, a});
        hwr(H_OFS_WDATA, d);
        hwr(H_OFS_CMD, 32'h1);
        repeat (4) @(posedge core_clk);
    endtask

    task automatic dev_rd(input logic [9:0] a, output logic [31:0] d);
        hwr(H_OFS_ADDR, {22'h0, a});
        hwr(H_OFS_CMD, 32'h2);
        repeat (4) @(posedge core_clk);
        hrd(H_OFS_RDATA, d);
    endtask

    task automatic test_regs();
        logic [31:0] d;
        dev_rd(OFS_INTR_CTRL, d);
        check(d, 32'h0);
        dev_rd(OFS_HARD_RESET, d);
        check(d, 32'h0);
        dev_wr(OFS_INTR_CTRL, 32'h23);
        dev_rd(OFS_INTR_CTRL, d);
        check(d, 32'h23);
        dev_wr(OFS_HARD_RESET, 32'h3);
        dev_rd(OFS_HARD_RESET, d);
        check(d, 32'h3);
        dev_wr(OFS_IRQ_PEND, 32'h2);
        dev_rd(OFS_IRQ_PEND, d);
        check(d, 32'h0);
        dev_rd(OFS_IRQ_CLEAR, d);
        check(d, 32'h0);
        dev_wr(OFS_INTR_CTRL, 32'h0);
        dev_wr(OFS_HARD_RESET, 32'h0);
        // Reserved write that aliases the low byte of the enable register
        dev_wr(10'h120, 32'h3);
        dev_rd(OFS_HARD_RESET, d);
        check(d, 32'h0);
        hwr(H_OFS_CTRL, 32'h2);
        dev_rd(OFS_LINK_STATUS, d);
        check(d & 32'h4, 32'h4);
        hwr(H_OFS_CTRL, 32'h0);
        $display("test_regs done");
    endtask

    task automatic test_decode();
        logic [9:0] a [7] = '{10'h050, 10'h0f4, 10'h200, 10'h2fc, 10'h300, 10'h334, 10'h004};
        logic [2:0] r [7] = '{3'h2, 3'h0, 3'h3, 3'h0, 3'h4, 3'h4, 3'h1};
        logic [31:0] d;
        for (int i = 0; i < 7; i++) begin
            dev_rd(a[i], d);
            if (i < 6) check(d, 32'h0);
            dev_rd(OFS_LINK_STATUS, d);
            check({29'h0, d[6:4]}, {29'h0, r[i]});
        end
        hrd(8'h40, d);
        check(d, 32'h0);
        $display("test_decode done");
    endtask

    task automatic test_rx();
        logic [31:0] d;
        int n;
        int t0;
        dev_wr(OFS_INTR_CTRL, 32'h1);
        hwr(H_OFS_CTRL, 32'hc);
        repeat (20) @(posedge core_clk);
        check({31'h0, req_out}, 32'h0);
        dev_wr(OFS_HARD_RESET, 32'h1);
        for (int i = 0; i < 20 && req_out !== 1'b1; i++) begin
            @(posedge core_clk);
            #1;
        end
        check({31'h0, req_out}, 32'h1);
        hwr(H_OFS_CTRL, 32'h8);
        repeat (10) @(posedge core_clk);
        check({31'h0, req_out}, 32'h1);
        check({31'h0, irq}, 32'h0);
        dev_rd(OFS_IRQ_PEND, d);
        check(d, 32'h2);
        dev_rd(OFS_LINK_STATUS, d);
        check(d & 32'h3, 32'h3);
        dev_rd(OFS_LINK_STATUS, d);
        check(d & 32'h3, 32'h1);
        dev_wr(OFS_INTR_CTRL, 32'h3);
        check({31'h0, irq}, 32'h1);
        dev_wr(OFS_IRQ_CLEAR, 32'h2);
        check({31'h0, irq}, 32'h0);
        dev_rd(OFS_IRQ_PEND, d);
        check(d, 32'h0);
        hwr(H_OFS_CTRL, 32'h1);
        repeat (4) @(posedge core_clk);
        check({31'h0, req_out}, 32'h0);
        hwr(H_OFS_CTRL, 32'h0);
        repeat (4) @(posedge core_clk);
        dev_wr(OFS_HARD_RESET, 32'h1);
        t0 = rclk_toggles;
        hwr(H_OFS_CTRL, 32'hc);
        n = 0;
        // Count frames the device takes before the request shows
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            #1;
            if (req_out === 1'b1) break;
            if (link.rx_bf === 1'b1 && link.rx_reset_bit === 1'b1) n++;
        end
        check(32'(n), 32'h4);
        check(32'(rclk_toggles - t0), 32'h4);
        hwr(H_OFS_CTRL, 32'h0);
        $display("test_rx done");
    endtask

    task automatic test_tx();
        logic [31:0] d;
        dev_wr(OFS_HARD_RESET, 32'h2);
        send_in <= 1'b1;
        d = 32'h0;
        // A hyperframe index wraps within about 512 cycles
        for (int i = 0; i < 15 && d[1] !== 1'b1; i++) begin
            repeat (60) @(posedge core_clk);
            hrd(H_OFS_STATUS, d);
        end
        check({31'h0, d[1]}, 32'h1);
        send_in <= 1'b0;
        dev_wr(OFS_HARD_RESET, 32'h0);
        hwr(H_OFS_STATUS, 32'h2);
        @(posedge core_clk);
        send_in <= 1'b1;
        repeat (600) @(posedge core_clk);
        hrd(H_OFS_STATUS, d);
        check({31'h0, d[1]}, 32'h0);
        send_in <= 1'b0;
        $display("test_tx done");
    endtask

    task automatic test_arst();
        @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        check({30'h0, req_out, irq}, 32'h0);
        @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        check({30'h0, req_out, irq}, 32'h0);
        $display("test_arst done");
    endtask

    initial begin
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        hwr(H_OFS_CTRL, 32'h0);
        repeat (4) @(posedge core_clk);
        test_regs();
        test_decode();
        test_rx();
        test_tx();
        test_arst();
        give_verdict();
    end

    // Tests need under two thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        $display("watchdog expired");
        give_verdict();
    end
endmodule // tb_top
